/* sabc_pkg.sv */
// Purpose: Shared constants for the converter bus-control block.
// Assumes: 100 MHz system clock; converter analog core outside this block.
// Notes:   Register map for the APB slave and sequencing figures.
package sabc_pkg;
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned RES_BITS         = 12;
    localparam int unsigned SHORT_BITS       = 8;
    // Approximation clock period per bit test, in ns
    localparam int unsigned BIT_TIME_NS      = 1000;
    localparam int unsigned BIT_CYCLES       = (BIT_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned DIV_W            = 8;
    // APB register byte offsets
    localparam logic [7:0]  OFS_CTRL         = 8'h00;
    localparam logic [7:0]  OFS_STATUS       = 8'h04;
    localparam logic [7:0]  OFS_RESULT       = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT     = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_MASK     = 8'h10;
    // Control register fields
    localparam int unsigned CTRL_SW_EN_BIT   = 0;
    localparam int unsigned CTRL_SW_BSEL_BIT = 1;
    localparam int unsigned CTRL_SW_WIDE_BIT = 2;
    localparam int unsigned CTRL_SW_GO_BIT   = 3;
    localparam logic [2:0]  CTRL_RESET       = 3'h0;
    // Interrupt status fields
    localparam int unsigned IRQ_DONE_BIT     = 0;
    localparam int unsigned IRQ_IGNORED_BIT  = 1;
    localparam int unsigned IRQ_W            = 2;
    localparam logic [1:0]  IRQ_MASK_RESET   = 2'h0;
    typedef enum logic [1:0] {
        SABC_IDLE   = 2'b00,
        SABC_LOAD   = 2'b01,
        SABC_TEST   = 2'b11,
        SABC_FINISH = 2'b10
    } sabc_state_type;
endpackage

/* sabc_top.sv */
// Purpose: Control and output logic of a 12-bit successive-approximation converter.
// Assumes: Pins arrive asynchronously; comparator result is valid one divider tick
//          after the trial code is driven.
// Notes:   APB gives software an alternative start path and a readout of the state.
// Functional notes
// R1 - No pin read or start happens unless chip enable is high and the low-active select is low.
// R2 - With both enables active, read/convert high reads and low starts a conversion.
// R3 - A start with byte select low runs all twelve bit trials.
// R4 - A start with byte select high runs only the top eight bit trials.
// R5 - In byte reads, byte select low drives the top eight bits, high the low four.
// R6 - Word-width high drives all twelve bits and ignores byte select on reads.
// R7 - The low-byte read carries the four low bits on top and four zeros below.
// R8 - Each byte read enables only the top eight lines so bytes share an 8-bit bus.
// R9 - The busy flag rises at conversion start and falls when the cycle ends.
// R10 - A start enables the bit clock, clears the trial code and tests MSB to LSB.
// R11 - A running conversion cannot be stopped and its lines stay undriven.
// R12 - Start requests during a running conversion are ignored.
// R13 - With enables fixed active, a falling read/convert edge starts a conversion.
// R14 - The finished result is held until the next accepted start.
//
// The register offsets and the APB slave port were decided locally.
module sabc_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        chip_enable,
    input  wire logic        chip_select_n,
    input  wire logic        read_convert,
    input  wire logic        byte_select,
    input  wire logic        word_wide,
    input  wire logic        comparator_high,
    output logic [11:0]      trial_code,
    output logic             bit_clock_en,
    output logic [11:0]      data_out,
    output logic [11:0]      data_oe,
    output logic             conversion_busy_flag,
    output logic             irq,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync1_next;
    logic [5:0] sync2_next;

    always_comb begin
        sync1_next = {comparator_high, word_wide, byte_select, read_convert,
                      chip_select_n, chip_enable};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    logic s_ce;
    logic s_cs_n;
    logic s_rc;
    logic s_bsel;
    logic s_wide;
    logic s_cmp;
    assign s_ce   = sync2_reg[0];
    assign s_cs_n = sync2_reg[1];
    assign s_rc   = sync2_reg[2];
    assign s_bsel = sync2_reg[3];
    assign s_wide = sync2_reg[4];
    assign s_cmp  = sync2_reg[5];

    ////////////////////////////////////////////////////////////////////////////
    // Software control
    logic [2:0]  ctrl_reg;
    logic [2:0]  ctrl_next;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_stat_next;
    logic [1:0]  irq_mask_reg;
    logic [1:0]  irq_mask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        sw_go;
    logic        done_evt;
    logic        ignore_evt;

    logic sel_en;
    logic sel_bsel;
    logic sel_wide;
    logic pin_enabled;
    logic rc_prev_reg;
    logic rc_prev_next;
    logic pin_start;
    logic pin_read;
    logic start_req;

    // Software takes over the select/format pins when its enable bit is set
    assign sel_en   = ctrl_reg[sabc_pkg::CTRL_SW_EN_BIT];
    assign sel_bsel = sel_en ? ctrl_reg[sabc_pkg::CTRL_SW_BSEL_BIT] : s_bsel;
    assign sel_wide = sel_en ? ctrl_reg[sabc_pkg::CTRL_SW_WIDE_BIT] : s_wide;
    assign pin_enabled = s_ce && !s_cs_n; // R1
    // Start on enabling with read/convert low, or on its fall with enables held
    assign rc_prev_next = pin_enabled ? s_rc : 1'b1;
    assign pin_start = pin_enabled && !s_rc && rc_prev_reg; // R2 R13
    assign pin_read  = pin_enabled && s_rc; // R2
    assign start_req = pin_start || sw_go;

    ////////////////////////////////////////////////////////////////////////////
    // Approximation sequencer
    sabc_pkg::sabc_state_type state_reg;
    sabc_pkg::sabc_state_type state_next;
    logic [11:0]              sar_reg;
    logic [11:0]              sar_next;
    logic [11:0]              mask_reg;
    logic [11:0]              mask_next;
    logic [11:0]              result_reg;
    logic [11:0]              result_next;
    logic                     short_reg;
    logic                     short_next;
    logic [sabc_pkg::DIV_W-1:0] div_reg;
    logic [sabc_pkg::DIV_W-1:0] div_next;
    logic                     tick;
    logic                     busy_reg;
    logic                     busy_next;
    logic                     clk_en_reg;
    logic                     clk_en_next;

    localparam logic [sabc_pkg::DIV_W-1:0] DIV_LAST =
        sabc_pkg::DIV_W'(sabc_pkg::BIT_CYCLES - 1);
    localparam logic [11:0] SHORT_LAST_MASK =
        12'h001 << (sabc_pkg::RES_BITS - sabc_pkg::SHORT_BITS);

    assign tick = (div_reg == DIV_LAST);

    always_comb begin
        state_next  = state_reg;
        sar_next    = sar_reg;
        mask_next   = mask_reg;
        result_next = result_reg;
        short_next  = short_reg;
        busy_next   = busy_reg;
        clk_en_next = clk_en_reg;
        div_next    = clk_en_reg ? (tick ? '0 : div_reg + 1'b1) : '0;
        done_evt    = 1'b0;
        ignore_evt  = 1'b0;
        case (state_reg)
            sabc_pkg::SABC_IDLE: begin
                if (start_req) begin
                    short_next  = sel_bsel; // R3 R4
                    busy_next   = 1'b1; // R9
                    clk_en_next = 1'b1; // R10
                    state_next  = sabc_pkg::SABC_LOAD;
                end
            end
            sabc_pkg::SABC_LOAD: begin
                sar_next   = 12'h800; // R10
                mask_next  = 12'h800;
                state_next = sabc_pkg::SABC_TEST;
            end
            sabc_pkg::SABC_TEST: begin
                ignore_evt = start_req; // R11 R12
                if (tick) begin
                    // Keep the trial bit unless the sum overshot the input
                    if (s_cmp) begin
                        sar_next = sar_reg & ~mask_reg; // R10
                    end
                    if ((mask_reg == 12'h001) ||
                        (short_reg && mask_reg == SHORT_LAST_MASK)) begin
                        state_next = sabc_pkg::SABC_FINISH; // R3 R4
                    end else begin
                        mask_next = mask_reg >> 1;
                        sar_next  = (s_cmp ? (sar_reg & ~mask_reg) : sar_reg)
                                    | (mask_reg >> 1);
                    end
                end
            end
            sabc_pkg::SABC_FINISH: begin
                ignore_evt  = start_req; // R12
                result_next = sar_reg; // R14
                busy_next   = 1'b0; // R9
                clk_en_next = 1'b0; // R10
                done_evt    = 1'b1;
                state_next  = sabc_pkg::SABC_IDLE;
            end
            default: begin
                state_next = sabc_pkg::SABC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= sabc_pkg::SABC_IDLE;
            sar_reg     <= 12'h000;
            mask_reg    <= 12'h000;
            result_reg  <= 12'h000;
            short_reg   <= 1'b0;
            div_reg     <= '0;
            busy_reg    <= 1'b0;
            clk_en_reg  <= 1'b0;
            rc_prev_reg <= 1'b1;
        end else begin
            state_reg   <= state_next;
            sar_reg     <= sar_next;
            mask_reg    <= mask_next;
            result_reg  <= result_next;
            short_reg   <= short_next;
            div_reg     <= div_next;
            busy_reg    <= busy_next;
            clk_en_reg  <= clk_en_next;
            rc_prev_reg <= rc_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output lines
    logic [11:0] dout_reg;
    logic [11:0] dout_next;
    logic [11:0] doe_reg;
    logic [11:0] doe_next;

    always_comb begin
        dout_next = 12'h000;
        doe_next  = 12'h000;
        if (pin_read && !busy_reg) begin // R1 R11
            if (sel_wide) begin
                dout_next = result_reg; // R6
                doe_next  = 12'hFFF;
            end else if (!sel_bsel) begin
                dout_next[11:4] = result_reg[11:4]; // R5
                doe_next[11:4]  = 8'hFF; // R8
            end else begin
                dout_next[11:4] = {result_reg[3:0], 4'h0}; // R5 R7
                doe_next[11:4]  = 8'hFF; // R8
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dout_reg <= 12'h000;
            doe_reg  <= 12'h000;
        end else begin
            dout_reg <= dout_next;
            doe_reg  <= doe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    logic       wr_acc;
    logic       rd_acc;
    logic       irq_reg;
    logic       irq_next;
    logic [1:0] evt_vec;

    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && !penable && !pwrite;
    assign evt_vec = {ignore_evt, done_evt};
    assign sw_go   = wr_acc && (paddr == sabc_pkg::OFS_CTRL)
                     && pwdata[sabc_pkg::CTRL_SW_GO_BIT];

    always_comb begin
        ctrl_next     = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        prdata_next   = prdata_reg;
        pslverr_next  = 1'b0;
        pready_next   = psel && !penable;
        if (wr_acc) begin
            case (paddr)
                sabc_pkg::OFS_CTRL:     ctrl_next     = pwdata[2:0];
                sabc_pkg::OFS_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata[1:0];
                sabc_pkg::OFS_IRQ_MASK: irq_mask_next = pwdata[1:0];
                default:                pslverr_next  = 1'b0;
            endcase
        end
        // Set beats clear when an event lands on the clearing write
        irq_stat_next = irq_stat_next | evt_vec;
        if (rd_acc) begin
            case (paddr)
                sabc_pkg::OFS_CTRL:     prdata_next = {29'h0, ctrl_reg};
                sabc_pkg::OFS_STATUS:   prdata_next = {30'h0, state_reg != sabc_pkg::SABC_IDLE,
                                                       busy_reg};
                sabc_pkg::OFS_RESULT:   prdata_next = {20'h0, result_reg};
                sabc_pkg::OFS_IRQ_STAT: prdata_next = {30'h0, irq_stat_reg};
                sabc_pkg::OFS_IRQ_MASK: prdata_next = {30'h0, irq_mask_reg};
                default:                prdata_next = 32'h0000_0000;
            endcase
        end
        if (psel && !penable) begin
            pslverr_next = !(paddr == sabc_pkg::OFS_CTRL || paddr == sabc_pkg::OFS_STATUS ||
                             paddr == sabc_pkg::OFS_RESULT ||
                             paddr == sabc_pkg::OFS_IRQ_STAT ||
                             paddr == sabc_pkg::OFS_IRQ_MASK);
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg     <= sabc_pkg::CTRL_RESET;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= sabc_pkg::IRQ_MASK_RESET;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            irq_reg      <= irq_next;
        end
    end

    assign trial_code           = sar_reg;
    assign bit_clock_en         = clk_en_reg;
    assign data_out             = dout_reg;
    assign data_oe              = doe_reg;
    assign conversion_busy_flag = busy_reg;
    assign irq                  = irq_reg;
    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
endmodule

/* sabc_chk.sv */
// Purpose: Port-level assertions for the converter control block.
// Assumes: One clock, asynchronous active-low reset, zero-wait bus slave.
// Notes:   Bound into sabc_top; sees its ports only.
module sabc_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        chip_enable,
    input wire logic        chip_select_n,
    input wire logic        read_convert,
    input wire logic        byte_select,
    input wire logic        word_wide,
    input wire logic [11:0] trial_code,
    input wire logic        bit_clock_en,
    input wire logic [11:0] data_out,
    input wire logic [11:0] data_oe,
    input wire logic        conversion_busy_flag,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic        en;
    logic [11:0] len_reg;
    logic [11:0] len_next;
    logic [3:0]  bits_reg;
    logic [3:0]  bits_next;
    assign en = chip_enable && !chip_select_n;
    ////////////////////////////////////////////////////////////////////////
    // Busy length counter; width taken at the first busy cycle
    always_comb begin
        len_next  = conversion_busy_flag ? len_reg + 12'h001 : 12'h000;
        bits_next = bits_reg;
        if (conversion_busy_flag && len_reg == 12'h000) begin
            bits_next = byte_select ? 4'h8 : 4'hC;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            len_reg  <= 12'h000;
            bits_reg <= 4'h0;
        end else begin
            len_reg  <= len_next;
            bits_reg <= bits_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_idle_quiet: assert property ((!en)[*6] |-> data_oe == 12'h000)
        else $error("lines driven while deselected");
    chk_convert_quiet: assert property ((en && !read_convert)[*6] |-> data_oe == 12'h000)
        else $error("lines driven on convert level");
    chk_line_shape: assert property (data_oe inside {12'h000, 12'hFF0, 12'hFFF})
        else $error("partial line group driven");
    chk_word_all: assert property ((en && read_convert && word_wide
        && !conversion_busy_flag)[*6] |-> data_oe == 12'hFFF)
        else $error("word read not on all lines");
    chk_low_zero: assert property ((en && read_convert && !word_wide && byte_select)[*6]
        ##0 data_oe == 12'hFF0 |-> data_out[7:4] == 4'h0)
        else $error("low byte trailing bits not zero");
    chk_busy_quiet: assert property (conversion_busy_flag
        && $past(conversion_busy_flag, 3) |-> data_oe == 12'h000)
        else $error("lines driven during conversion");
    chk_start_msb: assert property ($rose(conversion_busy_flag)
        |-> bit_clock_en ##1 trial_code == 12'h800)
        else $error("conversion did not start at msb");
    chk_clock_stop: assert property ($fell(conversion_busy_flag) |-> ##[0:3] !bit_clock_en)
        else $error("bit clock left running");
    chk_conv_len: assert property ($fell(conversion_busy_flag)
        |-> len_reg + 2 >= bits_reg * sabc_pkg::BIT_CYCLES
        && len_reg <= bits_reg * sabc_pkg::BIT_CYCLES + 10)
        else $error("conversion length wrong");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no zero-wait answer");
    cover property ($fell(conversion_busy_flag) && bits_reg == 4'h8);
    cover property (data_oe == 12'hFF0 && byte_select);
    cover property (pready && pslverr);
endmodule

bind sabc_top sabc_chk u_chk (
    .clk(clk), .reset_n(reset_n), .chip_enable(chip_enable),
    .chip_select_n(chip_select_n), .read_convert(read_convert),
    .byte_select(byte_select), .word_wide(word_wide), .trial_code(trial_code),
    .bit_clock_en(bit_clock_en), .data_out(data_out), .data_oe(data_oe),
    .conversion_busy_flag(conversion_busy_flag), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr)
);

/* sabc_analog.sv */
// Purpose: Behavioural comparator of the analog side.
// Assumes: Input level held steady through a conversion.
// Notes:   Ideal compare, so the result is the level truncated.
module sabc_analog (
    input  wire logic [11:0] trial_code,
    input  wire logic [11:0] level,
    output logic             comparator_high
);
    timeunit 1ns;
    timeprecision 1ps;
    // Overshoot drops the bit under test
    assign comparator_high = trial_code > level;
endmodule

/* sar_adc_bus_control_tb.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Zero-wait bus slave; pins pass a two-flop synchroniser.
// Notes:   Random levels from a fixed seed; conversion widths alternate.
module sar_adc_bus_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset_n, chip_enable, chip_select_n, read_convert;
    logic        byte_select, word_wide, comparator_high;
    logic        bit_clock_en, conversion_busy_flag, irq;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] trial_code, data_out, data_oe, level;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          fail_count = 0;
    int          compares = 0;
    int          seed = 51411;
    always #5 clk = ~clk;
    sabc_top u_dut (.clk(clk), .reset_n(reset_n), .chip_enable(chip_enable),
        .chip_select_n(chip_select_n), .read_convert(read_convert),
        .byte_select(byte_select), .word_wide(word_wide),
        .comparator_high(comparator_high), .trial_code(trial_code),
        .bit_clock_en(bit_clock_en), .data_out(data_out), .data_oe(data_oe),
        .conversion_busy_flag(conversion_busy_flag), .irq(irq), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sabc_analog u_an (.trial_code(trial_code), .level(level),
        .comparator_high(comparator_high));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Kind 0 busy high, 1 busy low, 2 any line driven
    task automatic hold_until(input int kind, input int lim);
        int n;
        n = 0;
        while (n < lim && !(kind == 0 ? conversion_busy_flag === 1'b1
               : kind == 1 ? conversion_busy_flag === 1'b0 : |data_oe === 1'b1)) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            $display("[ERR] %0t wait %0d timed out", $time, kind);
            tally_and_finish();
        end
    endtask
    task automatic pins(input logic ce, csn, rc, bs, ww);
        @(posedge clk);
        chip_enable <= ce;
        chip_select_n <= csn;
        read_convert <= rc;
        byte_select <= bs;
        word_wide <= ww;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("[ERR] %0t bus answer timed out", $time);
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Start a conversion; poke sends a read and a second start while busy
    task automatic convert(input logic bs, input logic poke);
        logic [31:0] rd;
        logic        err;
        pins(1'b0, 1'b1, 1'b0, bs, 1'b0);
        cyc(3);
        pins(1'b1, 1'b0, 1'b0, bs, 1'b0);
        hold_until(0, 20);
        if (poke) begin
            apb(1'b0, sabc_pkg::OFS_STATUS, 32'h0, rd, err);
            chk(rd[0], 1'b1);
            pins(1'b1, 1'b0, 1'b1, bs, 1'b0);
            cyc(10);
            pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        end
        hold_until(1, 1500);
        pins(1'b0, 1'b1, 1'b0, bs, 1'b0);
    endtask
    task automatic rd_pins(input logic ww, input logic bs, input logic [11:0] r);
        pins(1'b1, 1'b0, 1'b1, bs, ww);
        hold_until(2, 12);
        cyc(4);
        chk(data_oe, ww ? 12'hFFF : 12'hFF0);
        if (ww) chk(data_out, r);
        else chk(data_out[11:4], bs ? {r[3:0], 4'h0} : r[11:4]);
        pins(1'b0, 1'b1, 1'b1, bs, ww);
        cyc(4);
    endtask
    function automatic logic [11:0] exp_res(input logic [11:0] v, input logic bs);
        return bs ? {v[11:4], 4'h0} : v;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic        err;
        logic        bs;
        {reset_n, chip_enable, read_convert, byte_select, word_wide} = 5'h00;
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
        chip_select_n = 1'b1;
        level = 12'hA5C;
        cyc(6);
        reset_n <= 1'b1;
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        cyc(10);
        pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        cyc(10);
        chk(conversion_busy_flag, 1'b0);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        convert(1'b0, 1'b1);
        chk(irq, 1'b0);
        apb(1'b0, sabc_pkg::OFS_IRQ_STAT, 32'h0, rd, err);
        chk(rd[1:0], 2'h3);
        apb(1'b1, sabc_pkg::OFS_IRQ_MASK, 32'h1, rd, err);
        cyc(3);
        chk(irq, 1'b1);
        apb(1'b1, sabc_pkg::OFS_IRQ_STAT, 32'h3, rd, err);
        cyc(3);
        chk(irq, 1'b0);
        rd_pins(1'b1, 1'b1, 12'hA5C);
        for (int i = 0; i < 4; i++) begin
            level = 12'($random(seed));
            bs = i[0];
            convert(bs, 1'b0);
            rd_pins(1'b1, 1'b0, exp_res(level, bs));
            rd_pins(1'b0, 1'b0, exp_res(level, bs));
            rd_pins(1'b0, 1'b1, exp_res(level, bs));
            apb(1'b0, sabc_pkg::OFS_RESULT, 32'h0, rd, err);
            chk(rd, {20'h0, exp_res(level, bs)});
        end
        // Stand-alone use: enables held active, a falling read/convert starts
        pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        cyc(5);
        pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        hold_until(0, 20);
        hold_until(1, 1500);
        rd_pins(1'b1, 1'b0, level);
        // Software start; byte select pin kept equal to the override bit
        pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        apb(1'b1, sabc_pkg::OFS_CTRL, 32'h3, rd, err);
        apb(1'b1, sabc_pkg::OFS_CTRL, 32'hB, rd, err);
        hold_until(0, 20);
        apb(1'b0, sabc_pkg::OFS_STATUS, 32'h0, rd, err);
        chk(rd[1:0], 2'h3);
        hold_until(1, 1500);
        apb(1'b0, sabc_pkg::OFS_RESULT, 32'h0, rd, err);
        chk(rd, {20'h0, exp_res(level, 1'b1)});
        apb(1'b1, sabc_pkg::OFS_CTRL, 32'h0, rd, err);
        tally_and_finish();
    end
endmodule
